// file: hdl/dlirq_pkg.sv
// register map, field positions and bus codes for the data link and
// sync message interrupt block
// assumes a 32-bit axi4-lite bus; index = byte address / 4
package dlirq_pkg;
  localparam int          IDX_W          = 12;
  localparam int          ADDR_W         = IDX_W + 2;
  localparam int          SSM_MSG_W      = 6;
  localparam int          REPEAT_W       = 8;
  localparam logic [11:0] IDX_DL_STATUS  = 12'hB26;
  localparam logic [11:0] IDX_DL_ENABLE  = 12'hB27;
  localparam logic [11:0] IDX_SSM_STATUS = 12'hB70;
  localparam logic [11:0] IDX_SSM_ENABLE = 12'hB71;
  localparam logic [11:0] IDX_MATCH_ONE  = 12'hB7A;
  localparam logic [11:0] IDX_MATCH_TWO  = 12'hB7B;
  localparam logic [11:0] IDX_MATCH_THR  = 12'hB7C;
  localparam logic [11:0] IDX_TX_REPEAT  = 12'hB7D;
  localparam int DL_MSG_TYPE  = 7;
  localparam int DL_TX_START  = 6;
  localparam int DL_RX_START  = 5;
  localparam int DL_TX_END    = 4;
  localparam int DL_RX_END    = 3;
  localparam int DL_CHECKSUM  = 2;
  localparam int DL_ABORT     = 1;
  localparam int DL_FLAG      = 0;
  localparam int SSM_MATCH3   = 7;
  localparam int SSM_MATCH2   = 6;
  localparam int SSM_FULL     = 3;
  localparam int SSM_EMPTY    = 2;
  localparam int SSM_MATCH1   = 1;
  localparam int SSM_CHANGE   = 0;
  localparam logic [7:0] DL_ENABLE_MASK  = 8'h7F;
  localparam logic [7:0] DL_EVENT_MASK   = 8'h7F;
  localparam logic [7:0] SSM_FIELD_MASK  = 8'hCF;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] REPEAT_RESET    = 8'h01;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage

// file: hdl/dlirq_reg_if.sv
// register access strobes between the bus slave and the register file
// assumes one clock; strobes are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface dlirq_reg_if;
  logic                     wr_en;
  logic [dlirq_pkg::IDX_W-1:0] wr_index;
  logic [7:0]               wdata;
  logic                     wr_hit;
  logic                     rd_en;
  logic [dlirq_pkg::IDX_W-1:0] rd_index;
  logic [7:0]               rdata;
  logic                     rd_hit;
  modport bus  (output wr_en, wr_index, wdata, rd_en, rd_index,
                input  wr_hit, rdata, rd_hit);
  modport regs (input  wr_en, wr_index, wdata, rd_en, rd_index,
                output wr_hit, rdata, rd_hit);
endinterface
`default_nettype wire

// file: hdl/dlirq_axil_slave.sv
// axi4-lite slave turning bus transfers into register strobes
// assumes registers answer a read combinationally in the strobe cycle
`timescale 1ns/1ns
`default_nettype none
module dlirq_axil_slave (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [dlirq_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [dlirq_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  dlirq_reg_if.bus                         ri
);
  logic                         aw_held;
  logic                         w_held;
  logic [dlirq_pkg::IDX_W-1:0]  aw_index;
  logic [7:0]                   w_byte;
  logic                         w_lane;

  assign awready     = !aw_held && !bvalid;
  assign wready      = !w_held && !bvalid;
  assign arready     = !rvalid;
  assign ri.wr_en    = aw_held && w_held && !bvalid && w_lane;
  assign ri.wr_index = aw_index;
  assign ri.wdata    = w_byte;
  assign ri.rd_en    = arvalid && arready;
  assign ri.rd_index = araddr[dlirq_pkg::ADDR_W-1:2];

  // write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_index <= '0;
      w_byte   <= 8'h00;
      w_lane   <= 1'b0;
    end else if (aw_held && w_held && !bvalid) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held  <= 1'b1;
        aw_index <= awaddr[dlirq_pkg::ADDR_W-1:2];
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= dlirq_pkg::RESP_OKAY;
    end else if (aw_held && w_held && !bvalid) begin
      bvalid <= 1'b1;
      bresp  <= ri.wr_hit ? dlirq_pkg::RESP_OKAY : dlirq_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data captured in the strobe cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= dlirq_pkg::RESP_OKAY;
    end else if (ri.rd_en) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, ri.rdata};
      rresp  <= ri.rd_hit ? dlirq_pkg::RESP_OKAY : dlirq_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: hdl/dlirq_ssm_detect.sv
// compares each filter-validated sync message with three match values
// and with the previously validated message
// assumes msg_valid is a one-cycle pulse on the same clock
`timescale 1ns/1ns
`default_nettype none
module dlirq_ssm_detect #(
  parameter int MSG_W = dlirq_pkg::SSM_MSG_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             msg_valid,
  input  wire logic [MSG_W-1:0] msg,
  input  wire logic [MSG_W-1:0] match_one,
  input  wire logic [MSG_W-1:0] match_two,
  input  wire logic [MSG_W-1:0] match_three,
  output logic                  match_one_event,
  output logic                  match_two_event,
  output logic                  match_three_event,
  output logic                  detector_change_event
);
  logic             have_prev;
  logic [MSG_W-1:0] prev_msg;

  if (MSG_W < 1 || MSG_W > 8) begin : g_bad_width
    $error("message width must be 1 to 8");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_one_event       <= 1'b0;
      match_two_event       <= 1'b0;
      match_three_event     <= 1'b0;
      detector_change_event <= 1'b0;
    end else begin
      match_one_event       <= msg_valid && msg == match_one;
      match_two_event       <= msg_valid && msg == match_two;
      match_three_event     <= msg_valid && msg == match_three;
      detector_change_event <= msg_valid && (!have_prev || msg != prev_msg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_prev <= 1'b0;
      prev_msg  <= '0;
    end else if (msg_valid) begin
      have_prev <= 1'b1;
      prev_msg  <= msg;
    end
  end
endmodule
`default_nettype wire

// file: hdl/dlirq_top.sv
// data link and sync message interrupt enables, status and request
// assumes event inputs are one-cycle pulses from logic on aclk
// Function
// - tx start enable bit 6 gates interrupt
// - rx start enable bit 5 gates interrupt
// - tx end enable bit 4 gates interrupt
// - rx end enable bit 3 gates interrupt
// - checksum error enable bit 2 gates interrupt
// - abort enable bit 1 gates interrupt
// - flag octet enable bit 0 gates interrupt
// - status bit 7 on validated match three
// - status bit 6 on validated match two
// - status bit 1 on validated match one
// - status bit 3 on rx holding full
// - status bit 2 after programmed repeats sent
// - status bit 0 on validated message change
// - enable bit 3 gates holding full
// - enable bit 2 gates holding empty
// - enable bits 7, 6, 1 gate matches
// - enable bit 0 gates change; 5:4 reserved
// - link status bits 6:0 clear on read; bit 7 reads the live message type
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dlirq_top #(
  parameter int MSG_W    = dlirq_pkg::SSM_MSG_W,
  parameter int REPEAT_W = dlirq_pkg::REPEAT_W
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [dlirq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dlirq_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        rx_message_type,
  input  wire logic                        tx_start_event,
  input  wire logic                        rx_start_event,
  input  wire logic                        tx_end_event,
  input  wire logic                        rx_end_event,
  input  wire logic                        checksum_error_event,
  input  wire logic                        abort_seen_event,
  input  wire logic                        flag_seen_event,
  input  wire logic                        ssm_validated,
  input  wire logic [MSG_W-1:0]            rx_sync_message_holding,
  input  wire logic                        rx_holding_full_event,
  input  wire logic                        tx_holding_load,
  input  wire logic                        tx_message_sent,
  output logic                             irq
);
  logic [7:0]          dl_status;
  logic [7:0]          dl_enable;
  logic [7:0]          ssm_status;
  logic [7:0]          ssm_enable;
  logic [MSG_W-1:0]    match_one;
  logic [MSG_W-1:0]    match_two;
  logic [MSG_W-1:0]    match_three;
  logic [REPEAT_W-1:0] tx_repeat_count;
  logic [REPEAT_W-1:0] sent_count;
  logic                tx_armed;
  logic                tx_holding_empty_event;
  logic                match_one_event;
  logic                match_two_event;
  logic                match_three_event;
  logic                detector_change_event;
  logic [7:0]          dl_set;
  logic [7:0]          ssm_set;
  logic                rd_dl;
  logic                rd_ssm;
  logic                next_irq;

  if (REPEAT_W < 1 || REPEAT_W > 8) begin : g_bad_repeat
    $error("repeat count width must be 1 to 8");
  end

  dlirq_reg_if ri ();

  dlirq_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .ri      (ri)
  );

  dlirq_ssm_detect #(
    .MSG_W (MSG_W)
  ) u_ssm (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .msg_valid             (ssm_validated),
    .msg                   (rx_sync_message_holding),
    .match_one             (match_one),
    .match_two             (match_two),
    .match_three           (match_three),
    .match_one_event       (match_one_event),
    .match_two_event       (match_two_event),
    .match_three_event     (match_three_event),
    .detector_change_event (detector_change_event)
  );

  function automatic logic is_reg(input logic [dlirq_pkg::IDX_W-1:0] idx);
    is_reg = idx == dlirq_pkg::IDX_DL_STATUS  ||
             idx == dlirq_pkg::IDX_DL_ENABLE  ||
             idx == dlirq_pkg::IDX_SSM_STATUS ||
             idx == dlirq_pkg::IDX_SSM_ENABLE ||
             idx == dlirq_pkg::IDX_MATCH_ONE  ||
             idx == dlirq_pkg::IDX_MATCH_TWO  ||
             idx == dlirq_pkg::IDX_MATCH_THR  ||
             idx == dlirq_pkg::IDX_TX_REPEAT;
  endfunction

  function automatic logic [7:0] pad_msg(input logic [MSG_W-1:0] m);
    pad_msg = 8'(m);
  endfunction

  assign ri.wr_hit = is_reg(ri.wr_index);
  assign ri.rd_hit = is_reg(ri.rd_index);
  assign rd_dl     = ri.rd_en && ri.rd_index == dlirq_pkg::IDX_DL_STATUS;
  assign rd_ssm    = ri.rd_en && ri.rd_index == dlirq_pkg::IDX_SSM_STATUS;

  // read mux
  always_comb begin
    unique case (ri.rd_index)
      dlirq_pkg::IDX_DL_STATUS:
        ri.rdata = {rx_message_type, dl_status[6:0]};
      dlirq_pkg::IDX_DL_ENABLE:  ri.rdata = dl_enable;
      dlirq_pkg::IDX_SSM_STATUS: ri.rdata = ssm_status;
      dlirq_pkg::IDX_SSM_ENABLE: ri.rdata = ssm_enable;
      dlirq_pkg::IDX_MATCH_ONE:  ri.rdata = pad_msg(match_one);
      dlirq_pkg::IDX_MATCH_TWO:  ri.rdata = pad_msg(match_two);
      dlirq_pkg::IDX_MATCH_THR:  ri.rdata = pad_msg(match_three);
      dlirq_pkg::IDX_TX_REPEAT:  ri.rdata = 8'(tx_repeat_count);
      default:                   ri.rdata = 8'h00;
    endcase
  end

  // writable enables, masks keep reserved bits at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dl_enable  <= dlirq_pkg::REG_RESET;
      ssm_enable <= dlirq_pkg::REG_RESET;
    end else if (ri.wr_en) begin
      if (ri.wr_index == dlirq_pkg::IDX_DL_ENABLE)
        dl_enable <= ri.wdata & dlirq_pkg::DL_ENABLE_MASK;
      if (ri.wr_index == dlirq_pkg::IDX_SSM_ENABLE)
        ssm_enable <= ri.wdata & dlirq_pkg::SSM_FIELD_MASK;
    end
  end

  // match values and repeat count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_one       <= '0;
      match_two       <= '0;
      match_three     <= '0;
      tx_repeat_count <= REPEAT_W'(dlirq_pkg::REPEAT_RESET);
    end else if (ri.wr_en) begin
      if (ri.wr_index == dlirq_pkg::IDX_MATCH_ONE)
        match_one <= ri.wdata[MSG_W-1:0];
      if (ri.wr_index == dlirq_pkg::IDX_MATCH_TWO)
        match_two <= ri.wdata[MSG_W-1:0];
      if (ri.wr_index == dlirq_pkg::IDX_MATCH_THR)
        match_three <= ri.wdata[MSG_W-1:0];
      if (ri.wr_index == dlirq_pkg::IDX_TX_REPEAT)
        tx_repeat_count <= ri.wdata[REPEAT_W-1:0];
    end
  end

  // count repeats of the loaded message; zero is taken as one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sent_count             <= '0;
      tx_armed               <= 1'b0;
      tx_holding_empty_event <= 1'b0;
    end else begin
      tx_holding_empty_event <= 1'b0;
      if (tx_holding_load) begin
        sent_count <= '0;
        tx_armed   <= 1'b1;
      end else if (tx_message_sent && tx_armed) begin
        if (sent_count + 1'b1 >= tx_repeat_count) begin
          sent_count             <= '0;
          tx_armed               <= 1'b0;
          tx_holding_empty_event <= 1'b1;
        end else begin
          sent_count <= sent_count + 1'b1;
        end
      end
    end
  end

  always_comb begin
    dl_set = 8'h00;
    dl_set[dlirq_pkg::DL_TX_START] = tx_start_event;
    dl_set[dlirq_pkg::DL_RX_START] = rx_start_event;
    dl_set[dlirq_pkg::DL_TX_END]   = tx_end_event;
    dl_set[dlirq_pkg::DL_RX_END]   = rx_end_event;
    dl_set[dlirq_pkg::DL_CHECKSUM] = checksum_error_event;
    dl_set[dlirq_pkg::DL_ABORT]    = abort_seen_event;
    dl_set[dlirq_pkg::DL_FLAG]     = flag_seen_event;
    ssm_set = 8'h00;
    ssm_set[dlirq_pkg::SSM_MATCH3] = match_three_event;
    ssm_set[dlirq_pkg::SSM_MATCH2] = match_two_event;
    ssm_set[dlirq_pkg::SSM_FULL]   = rx_holding_full_event;
    ssm_set[dlirq_pkg::SSM_EMPTY]  = tx_holding_empty_event;
    ssm_set[dlirq_pkg::SSM_MATCH1] = match_one_event;
    ssm_set[dlirq_pkg::SSM_CHANGE] = detector_change_event;
  end

  // sticky status; an event in the read cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dl_status <= dlirq_pkg::REG_RESET;
    end else begin
      dl_status <= ((rd_dl ? 8'h00 : dl_status) | dl_set)
                   & dlirq_pkg::DL_EVENT_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ssm_status <= dlirq_pkg::REG_RESET;
    end else begin
      ssm_status <= (rd_ssm ? 8'h00 : ssm_status) | ssm_set;
    end
  end

  // gated request
  always_comb begin
    next_irq = |(dl_status & dl_enable)
               || |(ssm_status & ssm_enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_tx_start_gate;
    dl_status[dlirq_pkg::DL_TX_START] && dl_enable[dlirq_pkg::DL_TX_START]
      |=> irq;
  endproperty
  a_tx_start_gate: assert property (p_tx_start_gate)
    else $error("tx start enabled without request");

  property p_rx_start_set;
    rx_start_event |=> dl_status[dlirq_pkg::DL_RX_START];
  endproperty
  a_rx_start_set: assert property (p_rx_start_set)
    else $error("rx start event not recorded");

  property p_abort_set;
    abort_seen_event && dl_enable[dlirq_pkg::DL_ABORT] && !ri.wr_en
      |=> dl_status[dlirq_pkg::DL_ABORT] ##1 irq;
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("abort did not raise request");

  property p_match_three;
    ssm_validated && rx_sync_message_holding == match_three
      && $stable(match_three) |-> ##2 ssm_status[dlirq_pkg::SSM_MATCH3];
  endproperty
  a_match_three: assert property (p_match_three)
    else $error("match three not flagged two cycles on");

  property p_full_set;
    rx_holding_full_event |=> ssm_status[dlirq_pkg::SSM_FULL];
  endproperty
  a_full_set: assert property (p_full_set)
    else $error("holding full not recorded");

  property p_empty_set;
    tx_holding_empty_event |=> ssm_status[dlirq_pkg::SSM_EMPTY];
  endproperty
  a_empty_set: assert property (p_empty_set)
    else $error("holding empty not recorded");

  property p_reserved_zero;
    ssm_enable[5:4] == 2'b00 && dl_enable[7] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved enable bit set");

  property p_dl_clear;
    rd_dl && dl_set == 8'h00 |=> dl_status == 8'h00;
  endproperty
  a_dl_clear: assert property (p_dl_clear)
    else $error("link status not cleared by read");

  property p_ssm_clear;
    rd_ssm && ssm_set == 8'h00 |=> ssm_status == 8'h00;
  endproperty
  a_ssm_clear: assert property (p_ssm_clear)
    else $error("sync status not cleared by read");

  property p_quiet;
    (dl_status & dl_enable) == 8'h00 && (ssm_status & ssm_enable) == 8'h00
      |=> !irq;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("request without enabled status");

  c_dl_irq: cover property (tx_end_event ##[1:4] irq);
  c_match_irq: cover property (match_one_event ##2 irq);
  c_read_race: cover property (rd_ssm && ssm_set != 8'h00);
endmodule
`default_nettype wire

// file: dv/dlirq_line_model.sv
// far-side line terminal model: turns bench requests into event pulses
// assumes requests change just after a rising edge of aclk
`timescale 1ns/1ns
`default_nettype none
module dlirq_line_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [10:0] req,
  input  wire logic [5:0]  msg_in,
  output logic      [10:0] ev,
  output logic      [5:0]  msg
);
  // events: 6:0 link, 7 validated message, 8 full, 9 load, 10 sent
  always_ff @(posedge aclk) begin
    ev <= req;
  end
  // message value means nothing without a validated pulse, so it moves
  always_ff @(posedge aclk) begin
    if (!aresetn)
      msg <= 6'h2A;
    else
      msg <= req[7] ? msg_in : ~msg;
  end
endmodule
`default_nettype wire

// file: dv/dlirq_top_tb.sv
// self-checking bench for the link and sync message interrupt block
// assumes dlirq_pkg and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module dlirq_top_tb;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, msg_type;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [10:0] req, ev;
  logic [5:0]  msg_in, msg;
  int          errors, checks_done, cycles;
  logic [5:0]  m_tab [6] = '{6'h05, 6'h09, 6'h21, 6'h21, 6'h05, 6'h09};
  logic [7:0]  s_tab [6] = '{8'h03, 8'h41, 8'h81, 8'h80, 8'h03, 8'h41};
  logic [7:0]  e_tab [6] = '{8'h01, 8'h02, 8'h80, 8'hFF, 8'h02, 8'h40};
  dlirq_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .rx_message_type(msg_type),
    .tx_start_event(ev[6]), .rx_start_event(ev[5]), .tx_end_event(ev[4]),
    .rx_end_event(ev[3]), .checksum_error_event(ev[2]),
    .abort_seen_event(ev[1]), .flag_seen_event(ev[0]),
    .ssm_validated(ev[7]), .rx_sync_message_holding(msg),
    .rx_holding_full_event(ev[8]), .tx_holding_load(ev[9]),
    .tx_message_sent(ev[10]), .irq(irq));
  dlirq_line_model far (.aclk(aclk), .aresetn(aresetn), .req(req),
    .msg_in(msg_in), .ev(ev), .msg(msg));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic conclude;
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic pa, pw, ta, tw, done;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    done = 1'b0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
    end
    while (!done) begin
      @(negedge aclk);
      done = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] e,
                    input logic [1:0] er);
    logic pa, done;
    logic [31:0] d;
    logic [1:0] r;
    pa = 1'b1;
    done = 1'b0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    while (pa) begin
      @(negedge aclk);
      pa = !arready;
      @(posedge aclk);
      arvalid <= pa;
    end
    while (!done) begin
      @(negedge aclk);
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic fire(input int b, input logic [5:0] m);
    req <= 11'h1 << b;
    msg_in <= m;
    @(posedge aclk);
    req <= 11'h0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic irq_is(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, msg_type} = 4'h0;
    {awaddr, araddr, wdata, req, msg_in} = '0;
    {errors, checks_done, cycles} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(dlirq_pkg::IDX_DL_ENABLE, 8'h00, dlirq_pkg::RESP_OKAY);
    rd(dlirq_pkg::IDX_SSM_STATUS, 8'h00, dlirq_pkg::RESP_OKAY);
    rd(dlirq_pkg::IDX_SSM_ENABLE, 8'h00, dlirq_pkg::RESP_OKAY);
    rd(12'h004, 8'h00, dlirq_pkg::RESP_SLVERR);
    wr(12'h004, 8'hFF, dlirq_pkg::RESP_SLVERR);
    wr(dlirq_pkg::IDX_DL_ENABLE, 8'hFF, dlirq_pkg::RESP_OKAY);
    rd(dlirq_pkg::IDX_DL_ENABLE, 8'h7F, dlirq_pkg::RESP_OKAY);
    wr(dlirq_pkg::IDX_SSM_ENABLE, 8'hFF, dlirq_pkg::RESP_OKAY);
    rd(dlirq_pkg::IDX_SSM_ENABLE, 8'hCF, dlirq_pkg::RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      wr(dlirq_pkg::IDX_DL_ENABLE, 8'h7F & ~(8'h1 << i), 2'h0);
      fire(i, 6'h00);
      irq_is(1'b0);
      rd(dlirq_pkg::IDX_DL_STATUS, 8'h1 << i, 2'h0);
      wr(dlirq_pkg::IDX_DL_ENABLE, 8'h1 << i, 2'h0);
      fire(i, 6'h00);
      irq_is(1'b1);
      rd(dlirq_pkg::IDX_DL_STATUS, 8'h1 << i, 2'h0);
      irq_is(1'b0);
      rd(dlirq_pkg::IDX_DL_STATUS, 8'h00, 2'h0);
    end
    wr(dlirq_pkg::IDX_MATCH_ONE, 8'hC5, 2'h0);
    wr(dlirq_pkg::IDX_MATCH_TWO, 8'h09, 2'h0);
    wr(dlirq_pkg::IDX_MATCH_THR, 8'h21, 2'h0);
    rd(dlirq_pkg::IDX_MATCH_ONE, 8'h05, 2'h0);
    rd(dlirq_pkg::IDX_MATCH_THR, 8'h21, 2'h0);
    for (int k = 0; k < 6; k++) begin
      wr(dlirq_pkg::IDX_SSM_ENABLE, e_tab[k], 2'h0);
      fire(7, m_tab[k]);
      irq_is(|(e_tab[k] & s_tab[k]));
      rd(dlirq_pkg::IDX_SSM_STATUS, s_tab[k], 2'h0);
    end
    wr(dlirq_pkg::IDX_SSM_ENABLE, 8'h00, 2'h0);
    fire(8, 6'h00);
    irq_is(1'b0);
    wr(dlirq_pkg::IDX_SSM_ENABLE, 8'h08, 2'h0);
    irq_is(1'b1);
    rd(dlirq_pkg::IDX_SSM_STATUS, 8'h08, 2'h0);
    irq_is(1'b0);
    wr(dlirq_pkg::IDX_TX_REPEAT, 8'h02, 2'h0);
    wr(dlirq_pkg::IDX_SSM_ENABLE, 8'h04, 2'h0);
    fire(9, 6'h00);
    fire(10, 6'h00);
    irq_is(1'b0);
    fire(10, 6'h00);
    irq_is(1'b1);
    rd(dlirq_pkg::IDX_SSM_STATUS, 8'h04, 2'h0);
    fire(10, 6'h00);
    rd(dlirq_pkg::IDX_SSM_STATUS, 8'h00, 2'h0);
    msg_type <= 1'b1;
    @(posedge aclk);
    rd(dlirq_pkg::IDX_DL_STATUS, 8'h80, 2'h0);
    fire(8, 6'h00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(dlirq_pkg::IDX_SSM_STATUS, 8'h00, 2'h0);
    rd(dlirq_pkg::IDX_SSM_ENABLE, 8'h00, 2'h0);
    rd(dlirq_pkg::IDX_TX_REPEAT, 8'h01, 2'h0);
    conclude();
  end
endmodule
`default_nettype wire
